// ==== verilog/dkc_pkg.sv ====
package dkc_pkg;
   // host port offsets
   localparam logic [9:0] DKC_OFS_FLOW_STATUS = 10'h3F4;
   localparam logic [9:0] DKC_OFS_CMD_RESULT = 10'h3F5;
   // flow status bit positions
   localparam int DKC_MSR_READY_BIT = 7;
   localparam int DKC_MSR_DIR_BIT = 6;
   localparam int DKC_MSR_EXEC_BIT = 5;
   localparam int DKC_MSR_BUSY_BIT = 4;
   // operation codes (low five bits)
   localparam logic [4:0] DKC_OP_READ = 5'h06;
   localparam logic [4:0] DKC_OP_WRITE = 5'h05;
   localparam logic [4:0] DKC_OP_SEEK = 5'h0F;
   localparam logic [4:0] DKC_OP_RECAL = 5'h07;
   localparam logic [4:0] DKC_OP_SPECIFY = 5'h03;
   localparam logic [4:0] DKC_OP_SENSE_DRV = 5'h04;
   // timing
   localparam int DKC_CLK_MHZ = 25;
   localparam int DKC_STEP_PULSE_US = 4;
   localparam int DKC_STEP_PULSE_CYC = DKC_STEP_PULSE_US * DKC_CLK_MHZ;
   localparam int DKC_STEP_GAP_US = 8;
   localparam int DKC_STEP_GAP_CYC = DKC_STEP_GAP_US * DKC_CLK_MHZ;
   localparam logic [7:0] DKC_RECAL_MAX_STEPS = 8'h4F;
   localparam logic [7:0] DKC_DMA_BYTES = 8'h04;
   localparam logic [2:0] DKC_SYNC_RST = 3'h7;
   typedef enum logic [3:0] {
      DKC_IDLE = 4'b0001,
      DKC_CMD = 4'b0010,
      DKC_EXEC = 4'b0100,
      DKC_RES = 4'b1000
   } dkc_phase_type;
   typedef struct packed {
      logic index_n;
      logic outer_track_n;
      logic media_locked_n;
      logic door_opened_n;
   } dkc_drv_in_type;
   typedef struct packed {
      logic step_n;
      logic dir_n;
      logic write_gate_n;
      logic write_data_n;
      logic side_n;
      logic unit_one_pick_n;
      logic spindle_one_on_n;
   } dkc_drv_out_type;
endpackage

// ==== verilog/dkc_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1: phases run intake, execution, result in order
// R2: first byte opcode, later bytes parameters
// R3: host polls status before each byte
// R4: execution starts at last command byte
// R5: execution moves data, seeks, or stays internal
// R6: data moves by dma request and ack
// R7: result bytes read from data port
// R8: no-result commands return straight to intake
// R9: idle until a new command byte
// R10: write data only under write gate
// R11: heads moved by step pulse, direction pin
// R12: drive status inputs and read data sampled
// R13: status shows ready and byte direction
module dkc_ctrl (
   // system
   input wire logic sys_clk,
   input wire logic srst,
   // host i/o port
   input wire logic [9:0] io_addr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // dma channel two
   output logic dma_chan_two_request,
   input wire logic dma_chan_two_ack_n,
   input wire logic [7:0] dma_wdata,
   output logic [7:0] dma_rdata,
   // drive
   input wire dkc_pkg::dkc_drv_in_type drv_in,
   input wire logic read_data_n,
   output dkc_pkg::dkc_drv_out_type drv_out
);
   dkc_pkg::dkc_phase_type phase_r;
   logic [4:0] op_r;
   logic [3:0] left_r;
   logic [7:0] cyl_r, target_r, steps_r;
   logic [7:0] dma_cnt_r, dma_buf_r;
   logic [15:0] tmr_r;
   logic step_r, dir_r, gate_r, side_r;
   logic [1:0] nres_r, ridx_r;
   logic [7:0] st0_r;
   logic [2:0] s_idx, s_trk, s_wp, s_dc, s_rd, s_dack;
   logic idx_q, trk_q, wp_q, dc_q, rd_q, rd_prev_r;
   logic [7:0] pulse_cnt_r;
   logic acc_wr, acc_rd, dack_q, dack_prev_r, dma_beat;
   logic exec_done;

   // how many parameter bytes follow an opcode
   function automatic logic [3:0] param_count(input logic [4:0] op);
      unique case (op)
         dkc_pkg::DKC_OP_READ, dkc_pkg::DKC_OP_WRITE: param_count = 4'h8;
         dkc_pkg::DKC_OP_SEEK, dkc_pkg::DKC_OP_SPECIFY: param_count = 4'h2;
         dkc_pkg::DKC_OP_RECAL, dkc_pkg::DKC_OP_SENSE_DRV:
            param_count = 4'h1;
         default: param_count = 4'h0;
      endcase
   endfunction

   // specify and seek have no result bytes
   function automatic logic [1:0] result_count(input logic [4:0] op);
      unique case (op)
         dkc_pkg::DKC_OP_READ, dkc_pkg::DKC_OP_WRITE: result_count = 2'h3;
         dkc_pkg::DKC_OP_SENSE_DRV: result_count = 2'h1;
         dkc_pkg::DKC_OP_RECAL: result_count = 2'h2;
         default: result_count = 2'h0;
      endcase
   endfunction

   assign acc_wr = io_wr && io_addr == dkc_pkg::DKC_OFS_CMD_RESULT;
   assign acc_rd = io_rd && io_addr == dkc_pkg::DKC_OFS_CMD_RESULT;

   // three-stage synchronisers, change taken when stages 2 and 3 agree
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_idx <= dkc_pkg::DKC_SYNC_RST;
         s_trk <= dkc_pkg::DKC_SYNC_RST;
         s_wp <= dkc_pkg::DKC_SYNC_RST;
         s_dc <= dkc_pkg::DKC_SYNC_RST;
         s_rd <= dkc_pkg::DKC_SYNC_RST;
      end else begin
         s_idx <= {s_idx[1:0], drv_in.index_n}; // R12
         s_trk <= {s_trk[1:0], drv_in.outer_track_n}; // R12
         s_wp <= {s_wp[1:0], drv_in.media_locked_n}; // R12
         s_dc <= {s_dc[1:0], drv_in.door_opened_n}; // R12
         s_rd <= {s_rd[1:0], read_data_n}; // R12
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         idx_q <= 1'b1;
         trk_q <= 1'b1;
         wp_q <= 1'b1;
         dc_q <= 1'b1;
         rd_q <= 1'b1;
      end else begin
         if (s_idx[1] == s_idx[2]) idx_q <= s_idx[2];
         if (s_trk[1] == s_trk[2]) trk_q <= s_trk[2];
         if (s_wp[1] == s_wp[2]) wp_q <= s_wp[2];
         if (s_dc[1] == s_dc[2]) dc_q <= s_dc[2];
         if (s_rd[1] == s_rd[2]) rd_q <= s_rd[2];
      end
   end

   // read pulses counted so software can see the drive is streaming
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_prev_r <= 1'b1;
         pulse_cnt_r <= 8'h00;
      end else begin
         rd_prev_r <= rd_q;
         if (rd_prev_r && !rd_q) pulse_cnt_r <= pulse_cnt_r + 8'h01; // R12
      end
   end

   // dma ack is a pin: three-stage filter, each falling edge is one byte
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_dack <= dkc_pkg::DKC_SYNC_RST;
         dack_q <= 1'b1;
         dack_prev_r <= 1'b1;
      end else begin
         s_dack <= {s_dack[1:0], dma_chan_two_ack_n}; // R6
         if (s_dack[1] == s_dack[2]) dack_q <= s_dack[2];
         dack_prev_r <= dack_q;
      end
   end
   assign dma_beat = dack_prev_r && !dack_q && dma_chan_two_request;

   // execution finished this cycle
   always_comb begin
      unique case (op_r)
         dkc_pkg::DKC_OP_READ, dkc_pkg::DKC_OP_WRITE:
            exec_done = dma_beat && dma_cnt_r == 8'h01;
         dkc_pkg::DKC_OP_SEEK, dkc_pkg::DKC_OP_RECAL:
            exec_done = !step_r && tmr_r == 16'h0000 &&
               (op_r == dkc_pkg::DKC_OP_RECAL ? (!trk_q || steps_r == 8'h00)
                                             : cyl_r == target_r);
         default: exec_done = 1'b1; // R5
      endcase
   end

   // phase sequencing
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_r <= dkc_pkg::DKC_IDLE;
         op_r <= 5'h00;
         left_r <= 4'h0;
         nres_r <= 2'h0;
         ridx_r <= 2'h0;
      end else begin
         unique case (phase_r)
            dkc_pkg::DKC_IDLE: if (acc_wr) begin // R9
               op_r <= io_wdata[4:0]; // R2
               left_r <= param_count(io_wdata[4:0]);
               phase_r <= param_count(io_wdata[4:0]) == 4'h0 ?
                  dkc_pkg::DKC_EXEC : dkc_pkg::DKC_CMD; // R1
            end
            dkc_pkg::DKC_CMD: if (acc_wr) begin // R2
               left_r <= left_r - 4'h1;
               if (left_r == 4'h1) phase_r <= dkc_pkg::DKC_EXEC; // R4
            end
            dkc_pkg::DKC_EXEC: if (exec_done) begin
               nres_r <= result_count(op_r);
               ridx_r <= 2'h0;
               phase_r <= result_count(op_r) == 2'h0 ?
                  dkc_pkg::DKC_IDLE : dkc_pkg::DKC_RES; // R8
            end
            dkc_pkg::DKC_RES: if (acc_rd) begin // R7
               ridx_r <= ridx_r + 2'h1;
               if (ridx_r + 2'h1 == nres_r) phase_r <= dkc_pkg::DKC_IDLE;
            end
         endcase
      end
   end

   // parameter capture: second byte picks side, last seek byte is target
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         side_r <= 1'b0;
         target_r <= 8'h00;
      end else if (phase_r == dkc_pkg::DKC_CMD && acc_wr) begin
         if (left_r == param_count(op_r)) side_r <= io_wdata[2];
         if (op_r == dkc_pkg::DKC_OP_SEEK && left_r == 4'h1)
            target_r <= io_wdata;
      end
   end

   // head stepping
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         step_r <= 1'b0;
         dir_r <= 1'b0;
         tmr_r <= 16'h0000;
         cyl_r <= 8'h00;
         steps_r <= 8'h00;
      end else if (phase_r != dkc_pkg::DKC_EXEC) begin
         step_r <= 1'b0;
         tmr_r <= 16'h0000;
         steps_r <= dkc_pkg::DKC_RECAL_MAX_STEPS;
      end else if (tmr_r != 16'h0000) begin
         tmr_r <= tmr_r - 16'h0001;
      end else if (step_r) begin
         step_r <= 1'b0;
         // loading cycle counts too, so load one less
         tmr_r <= 16'(dkc_pkg::DKC_STEP_GAP_CYC - 1);
      end else if (op_r == dkc_pkg::DKC_OP_RECAL && !exec_done) begin
         dir_r <= 1'b0; // R11
         step_r <= 1'b1; // R11
         steps_r <= steps_r - 8'h01;
         tmr_r <= 16'(dkc_pkg::DKC_STEP_PULSE_CYC - 1);
      end else if (op_r == dkc_pkg::DKC_OP_RECAL) begin
         cyl_r <= 8'h00;
      end else if (op_r == dkc_pkg::DKC_OP_SEEK && !exec_done) begin
         dir_r <= target_r > cyl_r; // R11
         step_r <= 1'b1; // R11
         cyl_r <= target_r > cyl_r ? cyl_r + 8'h01 : cyl_r - 8'h01;
         tmr_r <= 16'(dkc_pkg::DKC_STEP_PULSE_CYC - 1);
      end
   end

   // dma data movement
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dma_cnt_r <= 8'h00;
         dma_buf_r <= 8'h00;
         gate_r <= 1'b0;
      end else if (phase_r != dkc_pkg::DKC_EXEC) begin
         dma_cnt_r <= dkc_pkg::DKC_DMA_BYTES;
         gate_r <= 1'b0;
      end else if (dma_beat) begin // R6
         dma_cnt_r <= dma_cnt_r - 8'h01;
         if (op_r == dkc_pkg::DKC_OP_WRITE) begin
            dma_buf_r <= dma_wdata;
            gate_r <= 1'b1; // R10
         end else begin
            dma_buf_r <= pulse_cnt_r;
         end
      end
   end

   assign dma_chan_two_request = phase_r == dkc_pkg::DKC_EXEC &&
      (op_r == dkc_pkg::DKC_OP_READ || op_r == dkc_pkg::DKC_OP_WRITE) &&
      !(op_r == dkc_pkg::DKC_OP_WRITE && !wp_q); // R6
   assign dma_rdata = dma_buf_r;

   // result byte zero reflects drive status seen during execution
   always_ff @(posedge sys_clk) begin
      if (srst) st0_r <= 8'h00;
      else if (phase_r == dkc_pkg::DKC_EXEC)
         st0_r <= {3'h0, !trk_q, !wp_q, !dc_q, !idx_q, side_r};
   end

   // host read data mux
   always_comb begin
      io_rdata = 8'h00;
      if (io_addr == dkc_pkg::DKC_OFS_FLOW_STATUS) begin // R3
         io_rdata[dkc_pkg::DKC_MSR_READY_BIT] =
            phase_r != dkc_pkg::DKC_EXEC; // R13
         io_rdata[dkc_pkg::DKC_MSR_DIR_BIT] =
            phase_r == dkc_pkg::DKC_RES; // R13
         io_rdata[dkc_pkg::DKC_MSR_EXEC_BIT] = phase_r == dkc_pkg::DKC_EXEC;
         io_rdata[dkc_pkg::DKC_MSR_BUSY_BIT] = phase_r != dkc_pkg::DKC_IDLE;
      end else if (io_addr == dkc_pkg::DKC_OFS_CMD_RESULT &&
                   phase_r == dkc_pkg::DKC_RES) begin
         unique case (ridx_r)
            2'h0: io_rdata = st0_r; // R7
            2'h1: io_rdata = cyl_r;
            2'h2: io_rdata = dma_buf_r;
            default: io_rdata = pulse_cnt_r;
         endcase
      end
   end

   // drive outputs, active low
   always_comb begin
      drv_out.step_n = !step_r; // R11
      drv_out.dir_n = !dir_r; // R11
      drv_out.write_gate_n = !gate_r; // R10
      drv_out.write_data_n = !(gate_r && dma_buf_r[0]); // R10
      drv_out.side_n = !side_r;
      drv_out.unit_one_pick_n = phase_r != dkc_pkg::DKC_EXEC;
      drv_out.spindle_one_on_n = phase_r != dkc_pkg::DKC_EXEC;
   end

   sequence s_last_byte;
      phase_r == dkc_pkg::DKC_CMD && acc_wr && left_r == 4'h1;
   endsequence
   AST_EXEC_AFTER_LAST: assert property (@(posedge sys_clk) disable iff (srst)
      s_last_byte |=> phase_r == dkc_pkg::DKC_EXEC) // R4
      else $error("execution did not start after last byte");
   AST_ORDER: assert property (@(posedge sys_clk) disable iff (srst)
      phase_r == dkc_pkg::DKC_RES |-> $past(phase_r) != dkc_pkg::DKC_CMD)
      // R1
      else $error("result phase entered from intake");
   AST_IDLE_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      phase_r == dkc_pkg::DKC_IDLE && !acc_wr |=>
      phase_r == dkc_pkg::DKC_IDLE) // R9
      else $error("left idle without a byte");
   AST_NO_RESULT: assert property (@(posedge sys_clk) disable iff (srst)
      phase_r == dkc_pkg::DKC_EXEC && exec_done &&
      result_count(op_r) == 2'h0 |=> phase_r == dkc_pkg::DKC_IDLE) // R8
      else $error("no-result command did not return to idle");
   AST_GATE: assert property (@(posedge sys_clk) disable iff (srst)
      !drv_out.write_data_n |-> !drv_out.write_gate_n) // R10
      else $error("write data without write gate");
   AST_STEP_LEN: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(step_r) |-> step_r [*8]) // R11
      else $error("step pulse too short");
   AST_MSR_DIR: assert property (@(posedge sys_clk) disable iff (srst)
      io_addr == dkc_pkg::DKC_OFS_FLOW_STATUS && phase_r == dkc_pkg::DKC_RES
      |-> io_rdata[7:6] == 2'b11) // R13
      else $error("status does not show result ready");
   AST_DMA_ONLY_EXEC: assert property (@(posedge sys_clk) disable iff (srst)
      dma_chan_two_request |-> phase_r == dkc_pkg::DKC_EXEC) // R6
      else $error("dma request outside execution");
   AST_RES_READS: assert property (@(posedge sys_clk) disable iff (srst)
      phase_r == dkc_pkg::DKC_RES && acc_rd && ridx_r + 2'h1 == nres_r
      |=> phase_r == dkc_pkg::DKC_IDLE) // R7
      else $error("result phase did not end after last byte");
endmodule // dkc_ctrl

// ==== verification/dkc_dma_model.sv ====
`timescale 1ns/1ps
module dkc_dma_model #(
   // ack must outlast the controller's three-stage filter plus capture
   parameter int HOLD = 8
) (
   // clock
   input wire logic sys_clk,
   // dma channel two
   input wire logic dma_chan_two_request,
   output logic dma_chan_two_ack_n,
   output logic [7:0] dma_wdata,
   // byte count seen by the host side
   output int acks
);
   initial begin
      dma_chan_two_ack_n = 1'b1;
      dma_wdata = 8'h5A;
      acks = 0;
      forever begin
         @(posedge sys_clk);
         if (dma_chan_two_request) begin
            dma_chan_two_ack_n <= 1'b0;
            dma_wdata <= 8'hA0 + acks[7:0];
            acks++;
            repeat (HOLD) @(posedge sys_clk);
            dma_chan_two_ack_n <= 1'b1;
            // released bus: show inverse, never the stale byte
            dma_wdata <= ~dma_wdata;
            repeat (HOLD) @(posedge sys_clk);
         end
      end
   end
endmodule // dkc_dma_model

// ==== verification/diskette_controller_phases_bench.sv ====
`timescale 1ns/1ps
module diskette_controller_phases_bench;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [9:0] io_addr = 10'h000;
   logic io_rd = 1'b0;
   logic io_wr = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic [7:0] dma_rdata;
   logic [7:0] dma_wdata;
   logic dma_chan_two_request;
   logic dma_chan_two_ack_n;
   dkc_pkg::dkc_drv_in_type drv_in = 4'hF;
   dkc_pkg::dkc_drv_out_type drv_out;
   logic read_data_n = 1'b1;
   logic [7:0] r[3];
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int steps = 0;
   int low = 0;
   logic gated = 1'b0;
   int acks;

   dkc_ctrl dut (.sys_clk(sys_clk), .srst(srst), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .dma_chan_two_request(dma_chan_two_request),
      .dma_chan_two_ack_n(dma_chan_two_ack_n), .dma_wdata(dma_wdata),
      .dma_rdata(dma_rdata), .drv_in(drv_in), .read_data_n(read_data_n),
      .drv_out(drv_out));
   dkc_dma_model dma (.sys_clk(sys_clk),
      .dma_chan_two_request(dma_chan_two_request),
      .dma_chan_two_ack_n(dma_chan_two_ack_n), .dma_wdata(dma_wdata),
      .acks(acks));

   always #20 sys_clk = ~sys_clk;

   task automatic stop_test;
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic fail(input string m);
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask

   task automatic chk(input logic [7:0] got, exp, input string m);
      checks++;
      if (got !== exp) fail(m);
   endtask

   // pulses, width checks and a cycle ceiling
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      read_data_n <= (cyc % 6) != 0;
      if (!drv_out.write_data_n && drv_out.write_gate_n)
         fail("write data without gate");
      if (!drv_out.write_gate_n)
         gated <= 1'b1;
      if (!drv_out.step_n)
         low <= low + 1;
      else if (low != 0) begin
         steps <= steps + 1;
         if (low != dkc_pkg::DKC_STEP_PULSE_CYC)
            fail("step width");
         low <= 0;
      end
      if (cyc == 20000) begin
         fail("timeout");
         stop_test();
      end
   end

   task automatic rd(input logic [9:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge sys_clk);
      v = io_rdata;
      io_rd <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= v;
      io_wr <= 1'b1;
      @(posedge sys_clk);
      io_wr <= 1'b0;
   endtask

   function automatic logic [7:0] st(input logic rdy, dir, ex, bsy);
      st = 8'h00;
      st[dkc_pkg::DKC_MSR_READY_BIT] = rdy;
      st[dkc_pkg::DKC_MSR_DIR_BIT] = dir;
      st[dkc_pkg::DKC_MSR_EXEC_BIT] = ex;
      st[dkc_pkg::DKC_MSR_BUSY_BIT] = bsy;
   endfunction

   task automatic wait_st(input logic [7:0] e, input int n);
      logic [7:0] v;
      for (int i = 0; i < n; i++) begin
         rd(dkc_pkg::DKC_OFS_FLOW_STATUS, v);
         if (v === e) break;
      end
      chk(v, e, "flow status");
   endtask

   // poll before every byte, as the host must
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         wait_st(st(1'b1, 1'b0, 1'b0, i != 0), 4);
         wr(dkc_pkg::DKC_OFS_CMD_RESULT, b[i]);
      end
   endtask

   task automatic results(input int n, input int w);
      for (int i = 0; i < n; i++) begin
         wait_st(st(1'b1, 1'b1, 1'b0, 1'b1), i == 0 ? w : 4);
         rd(dkc_pkg::DKC_OFS_CMD_RESULT, r[i]);
      end
      wait_st(st(1'b1, 1'b0, 1'b0, 1'b0), 4);
   endtask

   task automatic t_reset;
      logic [7:0] v;
      chk({1'b1, drv_out}, 8'hFF, "drive outputs idle");
      chk({7'h00, dma_chan_two_request}, 8'h00, "request idle");
      rd(dkc_pkg::DKC_OFS_CMD_RESULT, v);
      chk(v, 8'h00, "data port outside result");
      rd(10'h3F0, v);
      chk(v, 8'h00, "unmapped port");
   endtask

   task automatic t_seek;
      int s0;
      s0 = steps;
      send('{8'h0F, 8'h00, 8'h03});
      wait_st(st(1'b0, 1'b0, 1'b1, 1'b1), 2);
      // writes in execution must be ignored
      wr(dkc_pkg::DKC_OFS_CMD_RESULT, 8'h07);
      wait_st(st(1'b0, 1'b0, 1'b1, 1'b1), 1);
      wait_st(st(1'b1, 1'b0, 1'b0, 1'b0), 1000);
      chk(8'(steps - s0), 8'h03, "seek steps");
   endtask

   task automatic t_noresult;
      send('{8'h03, 8'hAA, 8'hBB});
      wait_st(st(1'b1, 1'b0, 1'b0, 1'b0), 8);
      send('{8'h1F});
      wait_st(st(1'b1, 1'b0, 1'b0, 1'b0), 8);
   endtask

   task automatic t_xfer(input logic [7:0] op);
      int a0;
      a0 = acks;
      send('{op, 8'h04, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      results(3, 400);
      chk({r[0][7:5], 5'h00}, 8'h00, "st0 top bits");
      chk({7'h00, r[0][0]}, 8'h01, "side from second byte");
      chk(r[1], 8'h03, "cylinder");
      chk(8'(acks - a0), 8'h04, "dma bytes");
      chk(dma_rdata, r[2], "dma byte out");
      if (op == 8'h05)
         chk(r[2], 8'hA0 + 8'(a0 + 3), "last dma byte");
      chk({7'h00, gated}, {7'h00, op == 8'h05}, "write gate");
   endtask

   task automatic t_recal;
      int s0;
      s0 = steps;
      send('{8'h07, 8'h00});
      for (int i = 0; i < 500 && steps == s0; i++)
         @(posedge sys_clk);
      drv_in.outer_track_n <= 1'b0;
      results(2, 1000);
      chk(r[1], 8'h00, "cylinder after recal");
      chk(r[0] & 8'h10, 8'h10, "outer track seen");
   endtask

   task automatic t_sense;
      logic [7:0] a;
      send('{8'h04, 8'h00});
      results(1, 50);
      a = r[0];
      drv_in.media_locked_n <= 1'b0;
      drv_in.door_opened_n <= 1'b0;
      drv_in.index_n <= 1'b0;
      // input passes three sync stages
      repeat (6) @(posedge sys_clk);
      send('{8'h04, 8'h00});
      results(1, 50);
      chk(r[0] ^ a, 8'h0E, "drive status bits");
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset();
      t_seek();
      t_noresult();
      t_xfer(8'h06);
      t_xfer(8'h05);
      t_recal();
      t_sense();
      stop_test();
   end
endmodule // diskette_controller_phases_bench
